// File: src/hbla_pkg.sv
// package: constants and carriers for the heater break/loop alarm block
package hbla_pkg;
  // current values in tenths of an ampere
  localparam int          CUR_W       = 10;
  localparam logic [9:0]  CUR_MAX     = 10'h01F4;  // 50.0 A display and setting top
  localparam logic [9:0]  CUR_OVR     = 10'h0226;  // 55.0 A over-range limit
  localparam logic [9:0]  HYST        = 10'h0002;  // 0.2 A fixed hysteresis
  localparam logic [9:0]  THR_OFF     = 10'h0000;  // threshold code meaning OFF
  localparam logic [9:0]  THR_RESET   = 10'h0000;  // thresholds start at OFF
  // control output kinds
  localparam logic [1:0]  OUT_CONTACT = 2'h0;
  localparam logic [1:0]  OUT_SSR     = 2'h1;
  localparam logic [1:0]  OUT_CURRENT = 2'h2;
  localparam logic [1:0]  OUT_VOLTAGE = 2'h3;
  // event output function codes
  localparam int          FN_W        = 5;
  localparam logic [4:0]  FN_BREAK    = 5'h1A;
  localparam logic [4:0]  FN_LOOP     = 5'h1B;
  localparam int          N_EVT       = 8;

  typedef enum logic [1:0] {
    HBLA_CHK_IDLE  = 2'b00,
    HBLA_CHK_WATCH = 2'b01
  } hbla_chk_e;

  // measurement front end sample
  typedef struct packed {
    logic             valid;   // a new sample stands on value
    logic             nodet;   // current cannot be detected
    logic [CUR_W-1:0] value;
  } hbla_meas_s;

  // monitor view of the measured current
  typedef struct packed {
    logic             over_range;
    logic             no_meas;
    logic [CUR_W-1:0] value;
  } hbla_mon_s;
endpackage : hbla_pkg

// File: src/hbla_cmp.sv
// threshold comparator with fixed hysteresis and real/lock hold
`timescale 1ns/1ps
module hbla_cmp #(
  parameter bit LOW_SIDE = 1'b1
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     sample,
  input  wire logic                     enable,
  input  wire logic                     hold_mode,
  input  wire logic [hbla_pkg::CUR_W-1:0] thr,
  input  wire logic [hbla_pkg::CUR_W-1:0] cur,
  output logic                          alarm
);
  typedef struct packed {
    logic alarm;
  } hbla_cmp_s;

  hbla_cmp_s st;
  hbla_cmp_s next_st;
  logic      trip;
  logic      clear;
  logic [hbla_pkg::CUR_W:0] thr_up;

  // trip and release points, hysteresis above the threshold on low-side release, below it on high-side release
  // fixed hysteresis
  always_comb begin
    thr_up = {1'b0, thr} + {1'b0, hbla_pkg::HYST};
    if (LOW_SIDE) begin
      trip  = cur < thr;
      clear = {1'b0, cur} >= thr_up;
    end else begin
      trip  = cur > thr;
      clear = {1'b0, cur} + {1'b0, hbla_pkg::HYST} <= {1'b0, thr};
    end
  end

  // alarm state: off threshold clears even a held alarm
  // real release
  always_comb begin
    next_st = st;
    if (thr == hbla_pkg::THR_OFF) begin
      next_st.alarm = 1'b0;
    end else if (sample && enable && trip) begin
      next_st.alarm = 1'b1;
    end else if (sample && clear && !hold_mode) begin
      next_st.alarm = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign alarm = st.alarm;
endmodule : hbla_cmp

// File: src/hbla_top.sv
// heater break and heater loop alarm logic
// Behaviour
// - alarms work only if supervised output is contact or SSR drive type
// - fixed 0.2 A hysteresis between alarm assert and release
// - break when no current during control, loop when current with output off
// - measured current monitored from 0.0 to 50.0 A in 0.1 A steps
// - over-range indication when current exceeds 55.0 A
// - no-measurement indication when current cannot be detected
// - break alarm when current below break threshold
// - break threshold OFF or 0.1..50.0 A, OFF at start disables it
// - loop alarm when current above loop threshold, OFF or 0.1..50.0 A
// - break alarm reaches an event output only if assigned break function
// - loop alarm reaches an event output only if assigned loop function
// - real mode, the default, releases alarm when current returns normal
// - lock mode holds alarm until threshold set OFF or power off
// - supervised output one or two, default one, two needs both usable
`timescale 1ns/1ps
module hbla_top #(
  parameter int N_EVT = hbla_pkg::N_EVT
) (
  input  wire logic                                  CLK,
  input  wire logic                                  RST,
  input  wire hbla_pkg::hbla_meas_s                  MEAS,
  input  wire logic                                  CONTROL_OUTPUT_ONE,
  input  wire logic                                  CONTROL_OUTPUT_TWO,
  input  wire logic [1:0]                            OUT_ONE_KIND,
  input  wire logic [1:0]                            OUT_TWO_KIND,
  input  wire logic                                  TWO_OUTPUT_CFG,
  input  wire logic [hbla_pkg::CUR_W-1:0]            BREAK_THRESHOLD,
  input  wire logic [hbla_pkg::CUR_W-1:0]            LOOP_THRESHOLD,
  input  wire logic                                  ALARM_HOLD_MODE,
  input  wire logic                                  BREAK_DETECT_OUTPUT_SELECT,
  input  wire logic [N_EVT*hbla_pkg::FN_W-1:0]       EVT_FUNCTION,
  output hbla_pkg::hbla_mon_s                        MONITOR,
  output logic                                       HEATER_BREAK_ALARM,
  output logic                                       HEATER_LOOP_ALARM,
  output logic [N_EVT-1:0]                           EVT_OUT
);
  // elaboration checks: refuse sizes that the routing and compare logic cannot serve
  if (N_EVT < 1 || N_EVT > 32) begin : g_bad_evt
    $error("N_EVT must be 1 to 32");
  end
  // current words must hold the over-range limit
  if (hbla_pkg::CUR_W < 10) begin : g_bad_cur
    $error("CUR_W too narrow for the over-range limit");
  end
  // function code field must hold the break and loop codes
  if (hbla_pkg::FN_W < 5) begin : g_bad_fn
    $error("FN_W too narrow for the alarm function codes");
  end

  typedef struct packed {
    hbla_pkg::hbla_meas_s      meas;      // registered sample
    logic                      ctl;       // supervised output level, registered
    logic                      usable;    // supervised output is contact/ssr
    logic                      sample;    // sample pulse into comparators
    hbla_pkg::hbla_mon_s       mon;
    logic                      heater_break_alarm;
    logic                      heater_loop_alarm;
    logic [N_EVT-1:0]          evt;
  } hbla_st_s;

  hbla_st_s st;
  hbla_st_s next_st;
  logic     brk_raw;
  logic     loop_raw;
  logic     sel_two;
  logic     kind_ok_one;
  logic     kind_ok_two;
  logic [hbla_pkg::CUR_W-1:0] brk_thr;
  logic [hbla_pkg::CUR_W-1:0] loop_thr;
  logic [hbla_pkg::CUR_W-1:0] cur_sat;
  logic     brk_en;
  logic     loop_en;
  logic     cur_over;
  logic     cur_high;
  logic [N_EVT-1:0] evt_brk;
  logic [N_EVT-1:0] evt_loop;

  // only contact and solid-state drive outputs switch the heater current cleanly
  // usable output kinds
  function automatic logic kind_usable(input logic [1:0] kind);
    return (kind == hbla_pkg::OUT_CONTACT) || (kind == hbla_pkg::OUT_SSR);
  endfunction : kind_usable

  // output kind checks and supervised output choice
  always_comb begin
    kind_ok_one = kind_usable(OUT_ONE_KIND);
    kind_ok_two = kind_usable(OUT_TWO_KIND);
    sel_two = BREAK_DETECT_OUTPUT_SELECT && TWO_OUTPUT_CFG && kind_ok_one && kind_ok_two;
  end

  // thresholds above range clamp to the top setting
  always_comb begin
    brk_thr  = (BREAK_THRESHOLD > hbla_pkg::CUR_MAX) ? hbla_pkg::CUR_MAX : BREAK_THRESHOLD;
    loop_thr = (LOOP_THRESHOLD > hbla_pkg::CUR_MAX) ? hbla_pkg::CUR_MAX : LOOP_THRESHOLD;
    cur_sat  = st.meas.nodet ? hbla_pkg::THR_OFF : st.meas.value;
  end

  // range flags of the held sample for the monitor view
  always_comb begin
    cur_over = !st.meas.nodet && (st.meas.value > hbla_pkg::CUR_OVR);
    cur_high = st.meas.value > hbla_pkg::CUR_MAX;
  end

  // comparator enables from the registered supervised output level
  always_comb begin
    brk_en  = st.usable && st.ctl;
    loop_en = st.usable && !st.ctl && !st.meas.nodet;
  end

  // per event output: match its function code against break and loop
  for (genvar i = 0; i < N_EVT; i++) begin : g_evt
    logic [hbla_pkg::FN_W-1:0] code;
    assign code = EVT_FUNCTION[i*hbla_pkg::FN_W +: hbla_pkg::FN_W];
    assign evt_brk[i]  = (code == hbla_pkg::FN_BREAK);
    assign evt_loop[i] = (code == hbla_pkg::FN_LOOP);
  end

  hbla_cmp #(
    .LOW_SIDE (1'b1)
  ) u_break (
    .clk       (CLK),
    .rst       (RST),
    .sample    (st.sample),
    .enable    (brk_en),
    .hold_mode (ALARM_HOLD_MODE),
    .thr       (brk_thr),
    .cur       (cur_sat),
    .alarm     (brk_raw)
  );

  hbla_cmp #(
    .LOW_SIDE (1'b0)
  ) u_loop (
    .clk       (CLK),
    .rst       (RST),
    .sample    (st.sample),
    .enable    (loop_en),
    .hold_mode (ALARM_HOLD_MODE),
    .thr       (loop_thr),
    .cur       (cur_sat),
    .alarm     (loop_raw)
  );

  // next state: sample capture, monitor, alarm routing
  always_comb begin
    next_st        = st;
    next_st.sample = MEAS.valid;
    if (MEAS.valid) begin
      next_st.meas = MEAS;
    end
    next_st.ctl    = sel_two ? CONTROL_OUTPUT_TWO : CONTROL_OUTPUT_ONE;
    next_st.usable = sel_two ? kind_ok_two : kind_ok_one;
    next_st.mon.no_meas    = st.meas.nodet;
    next_st.mon.over_range = cur_over;
    next_st.mon.value = (st.meas.nodet || cur_over) ? '0 :
                        cur_high ? hbla_pkg::CUR_MAX : st.meas.value;
    next_st.heater_break_alarm = brk_raw && st.usable;
    next_st.heater_loop_alarm = loop_raw && st.usable;
    next_st.evt = (evt_brk & {N_EVT{next_st.heater_break_alarm}}) | (evt_loop & {N_EVT{next_st.heater_loop_alarm}});
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign MONITOR            = st.mon;
  assign HEATER_BREAK_ALARM = st.heater_break_alarm;
  assign HEATER_LOOP_ALARM  = st.heater_loop_alarm;
  assign EVT_OUT            = st.evt;
endmodule : hbla_top

// File: sim/hbla_asserts.sv
// checker: port-level properties of the heater alarm block
`timescale 1ns/1ps
module hbla_asserts #(
  parameter int N_EVT = 8
) (
  input wire logic                             CLK,
  input wire logic                             RST,
  input wire hbla_pkg::hbla_meas_s             MEAS,
  input wire logic                             CONTROL_OUTPUT_ONE,
  input wire logic [1:0]                       OUT_ONE_KIND,
  input wire logic                             TWO_OUTPUT_CFG,
  input wire logic [hbla_pkg::CUR_W-1:0]       BREAK_THRESHOLD,
  input wire logic [hbla_pkg::CUR_W-1:0]       LOOP_THRESHOLD,
  input wire logic                             ALARM_HOLD_MODE,
  input wire logic [N_EVT*hbla_pkg::FN_W-1:0]  EVT_FUNCTION,
  input wire hbla_pkg::hbla_mon_s              MONITOR,
  input wire logic                             HEATER_BREAK_ALARM,
  input wire logic                             HEATER_LOOP_ALARM,
  input wire logic [N_EVT-1:0]                 EVT_OUT
);
  logic             use1;
  logic             ctl_on;
  logic             ctl_off;
  logic [N_EVT-1:0] exp_evt;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // output one supervised, usable, and its level
  assign use1 = !TWO_OUTPUT_CFG && !OUT_ONE_KIND[1];
  assign ctl_on = use1 && CONTROL_OUTPUT_ONE;
  assign ctl_off = use1 && !CONTROL_OUTPUT_ONE;
  // event outputs expected from their function codes
  always_comb begin
    for (int i = 0; i < N_EVT; i++) begin
      exp_evt[i] = (EVT_FUNCTION[i*5+:5] == hbla_pkg::FN_BREAK && HEATER_BREAK_ALARM) ||
                   (EVT_FUNCTION[i*5+:5] == hbla_pkg::FN_LOOP && HEATER_LOOP_ALARM);
    end
  end
  mon_over_a: assert property (
    MEAS.valid && !MEAS.nodet && MEAS.value > hbla_pkg::CUR_OVR |-> ##2 MONITOR.over_range)
    else $error("over-range flag missing");
  mon_nodet_a: assert property (
    MEAS.valid && MEAS.nodet |-> ##2 MONITOR.no_meas && MONITOR.value == 10'h0000)
    else $error("no-measurement flag missing");
  mon_value_a: assert property (
    MEAS.valid && !MEAS.nodet && MEAS.value <= hbla_pkg::CUR_MAX
    |-> ##2 MONITOR.value == $past(MEAS.value, 2)) else $error("monitor value wrong");
  brk_trip_a: assert property (
    ctl_on [*2] ##0 (MEAS.valid && !MEAS.nodet && MEAS.value < BREAK_THRESHOLD ##1 ctl_on [*2])
    |-> ##1 HEATER_BREAK_ALARM) else $error("break alarm not raised");
  brk_off_a: assert property (
    (BREAK_THRESHOLD == 10'h0000) [*4] |-> !HEATER_BREAK_ALARM) else $error("break alarm while off");
  kind_gate_a: assert property (
    (OUT_ONE_KIND[1] && !TWO_OUTPUT_CFG) [*4] |-> !HEATER_BREAK_ALARM && !HEATER_LOOP_ALARM)
    else $error("alarm on analogue output");
  loop_trip_a: assert property (
    ctl_off [*2] ##0 (MEAS.valid && !MEAS.nodet && MEAS.value > LOOP_THRESHOLD &&
    LOOP_THRESHOLD != 10'h0000 ##1 ctl_off [*2]) |-> ##1 HEATER_LOOP_ALARM)
    else $error("loop alarm not raised");
  lock_hold_a: assert property (
    (ALARM_HOLD_MODE && BREAK_THRESHOLD != 10'h0000) [*3] ##0 HEATER_BREAK_ALARM
    |=> HEATER_BREAK_ALARM) else $error("locked alarm dropped");
  loop_hold_a: assert property (
    (ALARM_HOLD_MODE && LOOP_THRESHOLD != 10'h0000) [*3] ##0 HEATER_LOOP_ALARM
    |=> HEATER_LOOP_ALARM) else $error("locked loop alarm dropped");
  loop_off_a: assert property (
    (LOOP_THRESHOLD == 10'h0000) [*4] |-> !HEATER_LOOP_ALARM) else $error("loop alarm while off");
  evt_map_a: assert property (
    $stable(EVT_FUNCTION) [*4] |-> EVT_OUT == exp_evt) else $error("event output wrong");
  cover property (HEATER_BREAK_ALARM && ALARM_HOLD_MODE);
  cover property (HEATER_LOOP_ALARM);
  cover property (MONITOR.over_range);
  cover property (HEATER_LOOP_ALARM && ALARM_HOLD_MODE);
endmodule : hbla_asserts

bind hbla_top hbla_asserts #(.N_EVT(N_EVT)) chk_u (
  .CLK(CLK), .RST(RST), .MEAS(MEAS), .CONTROL_OUTPUT_ONE(CONTROL_OUTPUT_ONE),
  .OUT_ONE_KIND(OUT_ONE_KIND), .TWO_OUTPUT_CFG(TWO_OUTPUT_CFG),
  .BREAK_THRESHOLD(BREAK_THRESHOLD), .LOOP_THRESHOLD(LOOP_THRESHOLD),
  .ALARM_HOLD_MODE(ALARM_HOLD_MODE), .EVT_FUNCTION(EVT_FUNCTION), .MONITOR(MONITOR),
  .HEATER_BREAK_ALARM(HEATER_BREAK_ALARM), .HEATER_LOOP_ALARM(HEATER_LOOP_ALARM),
  .EVT_OUT(EVT_OUT));

// File: sim/hbla_ct_model.sv
// current transformer front end: one sample pulse per request
`timescale 1ns/1ps
module hbla_ct_model (
  input  wire logic            clk,
  input  wire logic            go,
  input  wire logic            nodet,
  input  wire logic [9:0]      amps,
  output hbla_pkg::hbla_meas_s meas = '0
);
  // value line toggles between samples so stale data never looks valid
  always @(posedge clk) begin
    if (go) meas <= '{1'b1, nodet, amps};
    else meas <= '{1'b0, 1'b0, ~meas.value};
  end
endmodule : hbla_ct_model

// File: sim/hbla_top_test.sv
// testbench: corner and random current samples against the alarm block
`timescale 1ns/1ps
module hbla_top_test;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, nd = 1'b0, c1 = 1'b0, c2 = 1'b0;
  logic two = 1'b0, hold = 1'b0, sel = 1'b0, ba, la, eb = 1'b0, el = 1'b0;
  logic [1:0] k1 = 2'h0, k2 = 2'h1;
  logic [9:0] amps = 10'h0000, bthr = 10'h0000, lthr = 10'h0000;
  logic [9:0] corner [6] = '{10'h0000, 10'h01F4, 10'h01F5, 10'h0226, 10'h0227, 10'h03FF};
  logic [39:0] fn = {30'h0000_0000, hbla_pkg::FN_LOOP, hbla_pkg::FN_BREAK};
  logic [15:0] lf = 16'h0016;
  logic [7:0] evt;
  hbla_pkg::hbla_meas_s meas;
  hbla_pkg::hbla_mon_s mon;
  int mismatches = 0, comparisons = 0, cyc = 0;
  hbla_ct_model ct_u (.clk(clk), .go(go), .nodet(nd), .amps(amps), .meas(meas));
  hbla_top dut_u (.CLK(clk), .RST(rst), .MEAS(meas), .CONTROL_OUTPUT_ONE(c1),
    .CONTROL_OUTPUT_TWO(c2), .OUT_ONE_KIND(k1), .OUT_TWO_KIND(k2), .TWO_OUTPUT_CFG(two),
    .BREAK_THRESHOLD(bthr), .LOOP_THRESHOLD(lthr), .ALARM_HOLD_MODE(hold),
    .BREAK_DETECT_OUTPUT_SELECT(sel), .EVT_FUNCTION(fn), .MONITOR(mon),
    .HEATER_BREAK_ALARM(ba), .HEATER_LOOP_ALARM(la), .EVT_OUT(evt));
  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      report_and_stop;
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // monitor view expected for one sample
  function automatic logic [11:0] exp_mon(input logic [9:0] v, input logic n);
    if (n) return 12'h0400;
    if (v > hbla_pkg::CUR_OVR) return 12'h0800;
    return {2'b00, (v > hbla_pkg::CUR_MAX) ? hbla_pkg::CUR_MAX : v};
  endfunction : exp_mon
  // alarm pair expected after one sample, from the current settings
  function automatic logic [1:0] exp_alarm(input logic [9:0] v, input logic n);
    logic u2, ok, on, b, l;
    logic [9:0] cur;
    u2 = two && !k1[1] && !k2[1] && sel;
    ok = !(u2 ? k2[1] : k1[1]);
    on = u2 ? c2 : c1;
    cur = n ? 10'h0000 : v;
    b = eb;
    l = el;
    if (bthr == 10'h0000 || !ok) b = 1'b0;
    else if (on && cur < bthr) b = 1'b1;
    else if (!hold && cur >= bthr + 10'h0002) b = 1'b0;
    if (lthr == 10'h0000 || !ok) l = 1'b0;
    else if (!on && !n && cur > lthr) l = 1'b1;
    else if (!hold && cur + 10'h0002 <= lthr) l = 1'b0;
    return {b, l};
  endfunction : exp_alarm
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one sample through the front end, then all outputs compared
  task automatic smp(input logic [9:0] v, input logic n);
    @(negedge clk);
    {eb, el} = exp_alarm(v, n);
    go = 1'b1;
    amps = v;
    nd = n;
    @(negedge clk) go = 1'b0;
    repeat (5) @(negedge clk);
    chk({4'h0, mon}, {4'h0, exp_mon(v, n)});
    chk({6'h00, ba, la, evt}, {6'h00, eb, el, 6'h00, el, eb});
  endtask : smp
  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // monitor corners, break band, lock, output kinds, selection, loop band
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    foreach (corner[i]) smp(corner[i], 1'b0);
    smp(10'h0064, 1'b1);
    c1 = 1'b1;
    bthr = 10'h0064;
    for (int v = 99; v < 103; v++) smp(v[9:0], 1'b0);
    smp(10'h0064, 1'b1);
    for (int i = 0; i < 10; i++) begin
      lf = lfsr(lf);
      smp({2'b00, lf[7:0]}, 1'b0);
    end
    hold = 1'b1;
    smp(10'h0032, 1'b0);
    smp(10'h012C, 1'b0);
    bthr = 10'h0000;
    smp(10'h012C, 1'b0);
    hold = 1'b0;
    bthr = 10'h0064;
    for (int k = 2; k < 6; k++) begin
      k1 = k[1:0];
      smp(10'h0032, 1'b0);
    end
    smp(10'h00C8, 1'b0);
    two = 1'b1;
    sel = 1'b1;
    smp(10'h0032, 1'b0);
    c2 = 1'b1;
    smp(10'h0032, 1'b0);
    smp(10'h00C8, 1'b0);
    // output two refused when it is an analogue kind: output one stays watched
    k2 = 2'h2;
    smp(10'h0032, 1'b0);
    {two, sel, c1, bthr, lthr} = {3'b000, 10'h0000, 10'h00C8};
    for (int v = 201; v > 197; v--) smp(v[9:0], 1'b0);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      smp({2'b00, lf[7:0]}, 1'b0);
    end
    // lock mode on the loop alarm: held until its threshold goes off
    hold = 1'b1;
    smp(10'h012C, 1'b0);
    smp(10'h000A, 1'b0);
    lthr = 10'h0000;
    smp(10'h000A, 1'b0);
    report_and_stop;
  end
endmodule : hbla_top_test
